// ### include/dfc_pkg.sv
// Purpose: constants for the floor-adjust cycle pacing block
// Assumes: plain register port, 8-bit registers
// Notes: offsets of all three registers are free choices
package dfc_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CYCLE_CFG_ADDR = 8'h00;
	localparam logic [7:0] FLOOR_CTRL_ADDR = 8'h01;
	localparam logic [7:0] STATUS_ADDR = 8'h02;
	localparam logic [7:0] CYCLE_CFG_RESET = 8'h00;
	localparam logic [7:0] FLOOR_CTRL_RESET = 8'h00;
	localparam logic [7:0] OP_POINT_RESET = 8'h64;
	localparam int REMOTE_A_LSB = 0;
	localparam int LOCAL_LSB = 3;
	localparam int REMOTE_B_LO_LSB = 6;
	localparam int REMOTE_B_MSB_BIT = 0;
	localparam int REMOTE_A_EN_BIT = 5;
	localparam int LOCAL_EN_BIT = 6;
	localparam int REMOTE_B_EN_BIT = 7;
	localparam logic [7:0] FLOOR_CTRL_MASK = 8'he1;
	localparam int CODE_W = 3;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] BASE_DEC_WAIT = 11'h004;
	localparam int NUM_CH = 3;
endpackage

// ### hw/dfc_cycle_pacer.sv
// Purpose: floor-adjust cycle pacing configuration and per-channel pacers
// Assumes: monCycle pulses once per monitoring cycle from the sequencer
// Notes: thresholds and adjustment decisions live outside; targets are held here
// Summary of operation
// - Bits 2:0 pick remote A wait: decrease 4*2^n cycles, increase double.
// - Bits 5:3 pick local wait with the same encoding.
// - Bits 7:6 are the low bits of remote B code, MSB in floor control.
// - The assembled remote B code paces remote B like the other channels.
// - Pacing acts only while the channel's floor-adjust enable is set.
// - Operating points reset to 0x64 and serve as regulation target.
`timescale 1ns/10ps
`default_nettype none
module dfc_cycle_pacer (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic monCycle,
	input wire logic [2:0] adjustDone,
	output logic [2:0] decAllowed,
	output logic [2:0] incAllowed,
	output logic [2:0] floorAdjustEn,
	output logic [23:0] opPoint
);

	// Host-visible registers
	logic [7:0] cycleCfg_q;
	logic [7:0] floorCtrl_q;
	logic [7:0] floorCtrl_d;
	logic cfgWrSel;
	logic ctrlWrSel;

	// Operating points are fixed targets; this port cannot write them
	logic [7:0] opPointA_q;
	logic [7:0] opPointL_q;
	logic [7:0] opPointB_q;

	// Read path
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;
	logic [7:0] statusWord;

	// Remote A channel
	logic [dfc_pkg::CODE_W-1:0] codeA;
	logic enA;
	logic [dfc_pkg::CNT_W-1:0] decWaitA;
	logic [dfc_pkg::CNT_W-1:0] incWaitA;
	logic [dfc_pkg::CNT_W-1:0] cntA_q;
	logic [dfc_pkg::CNT_W-1:0] cntA_d;
	logic decReadyA;
	logic incReadyA;

	// Local channel
	logic [dfc_pkg::CODE_W-1:0] codeL;
	logic enL;
	logic [dfc_pkg::CNT_W-1:0] decWaitL;
	logic [dfc_pkg::CNT_W-1:0] incWaitL;
	logic [dfc_pkg::CNT_W-1:0] cntL_q;
	logic [dfc_pkg::CNT_W-1:0] cntL_d;
	logic decReadyL;
	logic incReadyL;

	// Remote B channel
	logic [dfc_pkg::CODE_W-1:0] codeB;
	logic enB;
	logic [dfc_pkg::CNT_W-1:0] decWaitB;
	logic [dfc_pkg::CNT_W-1:0] incWaitB;
	logic [dfc_pkg::CNT_W-1:0] cntB_q;
	logic [dfc_pkg::CNT_W-1:0] cntB_d;
	logic decReadyB;
	logic incReadyB;

	// Channel vectors, remote A in bit 0
	logic [2:0] enBits;
	logic [2:0] decReady;
	logic [2:0] incReady;

	// Decrease wait doubles with each code step
	function automatic logic [dfc_pkg::CNT_W-1:0] decWait(
		input logic [dfc_pkg::CODE_W-1:0] c
	);
		decWait = dfc_pkg::BASE_DEC_WAIT << c;
	endfunction

	// Longest increase wait still fits the counter width
	function automatic logic [dfc_pkg::CNT_W-1:0] incWait(
		input logic [dfc_pkg::CODE_W-1:0] c
	);
		incWait = decWait(c) << 1;
	endfunction

	// Count stops at the increase wait so an idle channel stays ready
	function automatic logic [dfc_pkg::CNT_W-1:0] nextCount(
		input logic [dfc_pkg::CNT_W-1:0] cnt,
		input logic en,
		input logic done,
		input logic tick,
		input logic [dfc_pkg::CNT_W-1:0] limit
	);
		if (!en || done) begin
			nextCount = '0;
		end else if (tick && cnt < limit) begin
			nextCount = cnt + 11'h001;
		end else begin
			nextCount = cnt;
		end
	endfunction

	function automatic logic waitMet(
		input logic [dfc_pkg::CNT_W-1:0] cnt,
		input logic [dfc_pkg::CNT_W-1:0] limit
	);
		waitMet = cnt >= limit;
	endfunction

	// Write decode
	assign cfgWrSel = regWr && (regAddr == dfc_pkg::CYCLE_CFG_ADDR);
	assign ctrlWrSel = regWr && (regAddr == dfc_pkg::FLOOR_CTRL_ADDR);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cycleCfg_q <= dfc_pkg::CYCLE_CFG_RESET;
		end else if (cfgWrSel) begin
			cycleCfg_q <= regWrData;
		end
	end

	// Reserved bits of floor control stay zero
	assign floorCtrl_d = regWrData & dfc_pkg::FLOOR_CTRL_MASK;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			floorCtrl_q <= dfc_pkg::FLOOR_CTRL_RESET;
		end else if (ctrlWrSel) begin
			floorCtrl_q <= floorCtrl_d;
		end
	end

	// Targets only reload on reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			opPointA_q <= dfc_pkg::OP_POINT_RESET;
			opPointL_q <= dfc_pkg::OP_POINT_RESET;
			opPointB_q <= dfc_pkg::OP_POINT_RESET;
		end
	end

	// Wait codes
	assign codeA = cycleCfg_q[dfc_pkg::REMOTE_A_LSB +: dfc_pkg::CODE_W];
	assign codeL = cycleCfg_q[dfc_pkg::LOCAL_LSB +: dfc_pkg::CODE_W];
	// Remote B code straddles both registers
	assign codeB = {floorCtrl_q[dfc_pkg::REMOTE_B_MSB_BIT],
		cycleCfg_q[dfc_pkg::REMOTE_B_LO_LSB +: dfc_pkg::CODE_W-1]};

	// Enables
	assign enA = floorCtrl_q[dfc_pkg::REMOTE_A_EN_BIT];
	assign enL = floorCtrl_q[dfc_pkg::LOCAL_EN_BIT];
	assign enB = floorCtrl_q[dfc_pkg::REMOTE_B_EN_BIT];
	assign enBits = {enB, enL, enA};

	// Wait lengths
	assign decWaitA = decWait(codeA);
	assign incWaitA = incWait(codeA);
	assign decWaitL = decWait(codeL);
	assign incWaitL = incWait(codeL);
	assign decWaitB = decWait(codeB);
	assign incWaitB = incWait(codeB);

	// Remote A pacer
	assign cntA_d = nextCount(cntA_q, enA, adjustDone[0], monCycle,
		incWaitA);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cntA_q <= '0;
		end else begin
			cntA_q <= cntA_d;
		end
	end

	assign decReadyA = waitMet(cntA_q, decWaitA);
	assign incReadyA = waitMet(cntA_q, incWaitA);

	// Local pacer
	assign cntL_d = nextCount(cntL_q, enL, adjustDone[1], monCycle,
		incWaitL);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cntL_q <= '0;
		end else begin
			cntL_q <= cntL_d;
		end
	end

	assign decReadyL = waitMet(cntL_q, decWaitL);
	assign incReadyL = waitMet(cntL_q, incWaitL);

	// Remote B pacer
	assign cntB_d = nextCount(cntB_q, enB, adjustDone[2], monCycle,
		incWaitB);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cntB_q <= '0;
		end else begin
			cntB_q <= cntB_d;
		end
	end

	assign decReadyB = waitMet(cntB_q, decWaitB);
	assign incReadyB = waitMet(cntB_q, incWaitB);

	// Gating by enable
	assign decReady = {decReadyB, decReadyL, decReadyA};
	assign incReady = {incReadyB, incReadyL, incReadyA};
	assign decAllowed = decReady & enBits;
	assign incAllowed = incReady & enBits;
	assign floorAdjustEn = enBits;

	// Status is not gated by enable; a disabled channel's count of zero reads as not ready
	assign statusWord = {2'h0, incReady, decReady};

	// Read data stand one cycle only, zero otherwise
	always_comb begin
		rdData_d = 8'h00;
		if (regRd) begin
			case (regAddr)
				dfc_pkg::CYCLE_CFG_ADDR: begin
					rdData_d = cycleCfg_q;
				end
				dfc_pkg::FLOOR_CTRL_ADDR: begin
					rdData_d = floorCtrl_q;
				end
				dfc_pkg::STATUS_ADDR: begin
					rdData_d = statusWord;
				end
				default: begin
					rdData_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= rdData_d;
		end
	end

	// Outputs
	assign regRdData = rdData_q;
	assign opPoint = {opPointB_q, opPointL_q, opPointA_q};

	// Pacing is a permission only; the caller decides to adjust
	// and then pulses adjustDone to restart the wait.
	// A code change mid-wait takes effect at once against
	// the running count, trading exactness for simplicity.
	// Counters never wrap: they saturate at the increase wait.
	// The read strobe has no side effects on any register.
endmodule // dfc_cycle_pacer
`default_nettype wire

// ### dv/dfc_pacer_properties.sv
// Purpose: port checks; Assumes: one clock; Notes: bind at foot of file
`timescale 1ns/10ps
`default_nettype none
module dfc_pacer_properties (input wire logic core_clk, resetn, regWr, regRd,
	input wire logic [7:0] regAddr, regWrData, regRdData,
	input wire logic [2:0] floorAdjustEn, decAllowed, incAllowed, adjustDone,
	input wire logic [23:0] opPoint);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_op_fixed: assert property (opPoint == 24'h646464) else $error("op");
	a_rd_idle: assert property (!$past(regRd) |-> !regRdData) else $error("rd");
	a_inc_dec: assert property (!(incAllowed & ~decAllowed))
		else $error("inc before dec");
	a_en_write: assert property (regWr && regAddr == 8'h01 |=>
		floorAdjustEn == $past(regWrData[7:5])) else $error("enable");
	a_adj_clear: assert property (|adjustDone |=>
		!((decAllowed | incAllowed) & $past(adjustDone))) else $error("adj");
	a_off_idle: assert property (!((decAllowed | incAllowed) &
		~(floorAdjustEn | $past(floorAdjustEn)))) else $error("off");
	a_cfg_back: assert property (regWr && !regAddr ##2 regRd && !regAddr
		|=> regRdData == $past(regWrData, 3)) else $error("cfg");
	cover property (decAllowed[2]);
	cover property (incAllowed[0]);
	cover property (|adjustDone);
endmodule // dfc_pacer_properties
bind dfc_cycle_pacer dfc_pacer_properties chk (.*);
`default_nettype wire

// ### dv/dfc_cycle_pacer_tb_top.sv
// Purpose: pacer bench; Assumes: 10 MHz; Notes: ctl packs strobes for one NBA
`timescale 1ns/10ps
`default_nettype none
module dfc_cycle_pacer_tb_top;
	logic core_clk = 0, resetn = 0, regWr, regRd, monCycle;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, v;
	logic [2:0] adjustDone, decAllowed, incAllowed, floorAdjustEn;
	logic [5:0] ctl = 6'h00;
	logic [23:0] opPoint;
	int num_errors = 0, checked = 0, cyc = 0;
	assign {regWr, regRd, monCycle, adjustDone} = ctl;
	dfc_cycle_pacer dut (.*);
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cyc > 20000) finish_test(1);
	task automatic cmp(logic [7:0] g, e);
		checked++;
		num_errors += int'(g !== e);
		if (g !== e) $display("ERROR %0t %h %h", $time, g, e);
	endtask
	task automatic drv(logic [5:0] op, logic [7:0] a, d);
		@(posedge core_clk) {ctl, regAddr, regWrData} <= {op, a, d};
		@(posedge core_clk) ctl <= 6'h00;
		@(negedge core_clk);
	endtask
	task automatic finish_test(int t);
		if (num_errors + t == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		drv(6'h10, 8'h00, 8'h00);
		cmp(regRdData, 8'h00);
		drv(6'h20, 8'h01, 8'hff);
		cmp(8'(floorAdjustEn), 8'h07);
		drv(6'h10, 8'h01, 8'h00);
		cmp(regRdData, 8'he1);
		drv(6'h10, 8'h02, 8'h00);
		cmp(regRdData, 8'h00);
		cmp(opPoint[7:0], 8'h64);
		cmp(opPoint[15:8], 8'h64);
		cmp(opPoint[23:16], 8'h64);
		for (int c = 0; c < 3; c++) for (int n = 0; n < 8; n++) begin
			v = 8'(c > 1 ? n << 6 : n << 3 * c);
			drv(6'h20, 8'h01, 8'h00);
			drv(6'h20, 8'h00, v);
			drv(6'h10, 8'h00, 8'h00);
			cmp(regRdData, v);
			drv(6'h20, 8'h01, 8'(32 << c | (c > 1 ? n >> 2 : 0)));
			cmp(8'(floorAdjustEn), 8'(1 << c));
			for (int k = 1; k <= 8 << n; k++) begin
				drv(6'h08, 8'h00, 8'h00);
				cmp(8'({incAllowed[c], decAllowed[c]}),
					8'({k >= 8 << n, k >= 4 << n}));
			end
			drv(6'h10, 8'h02, 8'h00);
			cmp(regRdData, 8'(9 << c));
			drv(6'(1 << c), 8'h00, 8'h00);
			cmp(8'({incAllowed[c], decAllowed[c]}), 8'h00);
		end
		@(posedge core_clk) resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		drv(6'h10, 8'h00, 8'h00);
		cmp(regRdData, 8'h00);
		cmp(8'(floorAdjustEn), 8'h00);
		finish_test(0);
	end
endmodule // dfc_cycle_pacer_tb_top
`default_nettype wire
